// >>> hw/pstart_pkg.sv
// Shared constants and types for the positioning start command handler.
package pstart_pkg;
    // Control block word indexes; byte address is four times the index.
    localparam int IDX_SYS = 0;
    localparam int IDX_STATUS = 1;
    localparam int IDX_STARTNO = 2;
    localparam int IDX_CTRL = 3;
    localparam int IDX_FLAGS = 4;
    localparam int IDX_IRQ_STAT = 5;
    localparam int IDX_IRQ_MASK = 6;
    localparam int IDX_LAST = 6;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_AXIS_LSB = 1;
    localparam int CTRL_STOP_BIT = 3;
    localparam int CTRL_CREADY_BIT = 4;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam logic [15:0] STATUS_OK = 16'h0000;
    localparam logic [15:0] ERR_RANGE = 16'h1862;
    localparam logic [15:0] ERR_AXIS = 16'h1865;
    localparam logic [15:0] POS_MIN = 16'h0001;
    localparam logic [15:0] POS_MAX = 16'h0258;
    localparam logic [15:0] BLK_MIN = 16'h1b58;
    localparam logic [15:0] BLK_MAX = 16'h1b5c;
    localparam logic [15:0] SPC_MACH_ORIGIN = 16'h2329;
    localparam logic [15:0] SPC_FAST_ORIGIN = 16'h232a;
    localparam logic [15:0] SPC_PV_CHANGE = 16'h232b;
    localparam logic [15:0] SPC_MULTI = 16'h232c;
    localparam logic [15:0] STARTNO_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CLK_PERIOD_NS = 10;
    localparam int START_DELAY_NS = 880000;
    // Longest delay: rounded down to whole cycles.
    localparam int START_DELAY_CYCLES = START_DELAY_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        K_POS = 3'h0,
        K_BLOCK = 3'h1,
        K_MACH_ORIGIN = 3'h2,
        K_FAST_ORIGIN = 3'h3,
        K_PV_CHANGE = 3'h4,
        K_MULTI = 3'h5,
        K_BAD = 3'h7
    } start_kind_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_LAUNCH = 3'h1,
        S_RUN = 3'h3,
        S_FINISH = 3'h2,
        S_HOLD = 3'h6
    } cmd_state_t;

    // Command toward the motion core; start and stop are one-cycle pulses.
    typedef struct packed {
        logic [3:0] start;
        logic [3:0] stop;
        start_kind_t kind;
        logic [15:0] number;
    } motion_cmd_t;
endpackage

// >>> hw/positioning_start_command.sv
// Positioning start command handler with an AXI4-Lite register slave.
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
// Function
// - Start number decoded by its three ranges
// - Codes 9001-9004 select origin, change, multi
// - Status word: zero success, else error code
// - Completion flag high exactly one scan
// - Error flag pulses with completion on error
// - Start goes only to the selected axis
// - Progress shown by busy, start-complete brief
// - Stop during run ends command, flags completion
// - Requests ignored while module not ready
// - Multi-axis start completes on own axis
// - Launch delay bounded by 0.88 ms
// - Out-of-range number on an implemented axis gives range error code
// - Unimplemented axis gives axis error code
// - Block: reserved, status, start number words
module positioning_start_command
    import pstart_pkg::*;
#(
    parameter int NUM_AXES = 4,
    parameter int ADDR_W = 8,
    parameter int START_DELAY = START_DELAY_CYCLES
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scan_end,
    input wire logic module_ready_in,
    input wire logic [3:0] axis_busy_in,
    input wire logic [3:0] axis_done_in,
    output motion_cmd_t motion_cmd,
    output logic controller_ready_out,
    output logic [3:0] start_complete_out,
    output logic [3:0] axis_busy_output,
    output logic complete_flag,
    output logic error_flag,
    output logic irq
);
    localparam int CW = $clog2(START_DELAY + 1);
    localparam logic [CW-1:0] DELAY_LAST = CW'(START_DELAY - 1);

    function automatic start_kind_t decode_start(input logic [15:0] n);
        if (n >= POS_MIN && n <= POS_MAX) decode_start = K_POS;
        else if (n >= BLK_MIN && n <= BLK_MAX) decode_start = K_BLOCK;
        else if (n == SPC_MACH_ORIGIN) decode_start = K_MACH_ORIGIN;
        else if (n == SPC_FAST_ORIGIN) decode_start = K_FAST_ORIGIN;
        else if (n == SPC_PV_CHANGE) decode_start = K_PV_CHANGE;
        else if (n == SPC_MULTI) decode_start = K_MULTI;
        else decode_start = K_BAD;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        for (int i = 0; i < 4; i++)
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    endfunction

    cmd_state_t state_reg;
    logic [1:0] axis_reg;
    logic [15:0] number_reg;
    logic [15:0] code_reg;
    logic [15:0] status_reg;
    logic [15:0] startno_reg;
    logic [1:0] ctrl_axis_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [CW-1:0] delay_cnt_reg;
    logic ready_meta_reg;
    logic ready_sync_reg;
    logic start_req_reg;
    logic stop_req_reg;
    logic aw_got_reg;
    logic w_got_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    wire wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
    wire [ADDR_W-3:0] wr_idx = awaddr_reg[ADDR_W-1:2];
    wire [ADDR_W-3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
    wire [31:0] ctrl_old = {27'h0, controller_ready_out, 1'b0, ctrl_axis_reg, 1'b0};
    wire [31:0] ctrl_new = merge(ctrl_old, wdata_reg, wstrb_reg);
    wire [31:0] startno_new = merge({16'h0, startno_reg}, wdata_reg, wstrb_reg);
    wire [31:0] mask_new = merge({30'h0, irq_mask_reg}, wdata_reg, wstrb_reg);
    wire done_event = complete_flag == 1'b0 && state_reg == S_FINISH && scan_end;

    // Module ready comes from another module's pins, so it is synchronised first.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ready_meta_reg <= 1'b0;
            ready_sync_reg <= 1'b0;
        end
        else
        begin
            ready_meta_reg <= module_ready_in;
            ready_sync_reg <= ready_meta_reg;
        end
    end

    // Write channel: address and data are taken in either order.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_reg <= s_axi_awaddr;
                aw_got_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                w_got_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (int'(wr_idx) > IDX_LAST) ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register writes; start and stop bits act once and read back as zero.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            startno_reg <= STARTNO_RESET;
            ctrl_axis_reg <= 2'h0;
            controller_ready_out <= 1'b0;
            irq_mask_reg <= 2'h0;
            start_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
        end
        else
        begin
            start_req_reg <= 1'b0;
            stop_req_reg <= 1'b0;
            if (wr_fire)
            begin
                if (int'(wr_idx) == IDX_STARTNO)
                    startno_reg <= startno_new[15:0];
                else if (int'(wr_idx) == IDX_CTRL)
                begin
                    ctrl_axis_reg <= ctrl_new[CTRL_AXIS_LSB +: 2];
                    controller_ready_out <= ctrl_new[CTRL_CREADY_BIT];
                    start_req_reg <= ctrl_new[CTRL_START_BIT];
                    stop_req_reg <= ctrl_new[CTRL_STOP_BIT];
                end
                else if (int'(wr_idx) == IDX_IRQ_MASK)
                    irq_mask_reg <= mask_new[1:0];
            end
        end
    end

    // Interrupt status: an event in the clearing cycle stays set.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_stat_reg <= 2'h0;
            irq <= 1'b0;
        end
        else
        begin
            logic [1:0] clr;
            logic [1:0] set;
            clr = (wr_fire && int'(wr_idx) == IDX_IRQ_STAT && wstrb_reg[0]) ? wdata_reg[1:0] : 2'h0;
            set = {done_event && code_reg != STATUS_OK, done_event};
            irq_stat_reg <= (irq_stat_reg & ~clr) | set;
            irq <= |(((irq_stat_reg & ~clr) | set) & irq_mask_reg);
        end
    end

    // Read channel.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (int'(rd_idx) == IDX_SYS)
                s_axi_rdata <= 32'h0;
            else if (int'(rd_idx) == IDX_STATUS)
                s_axi_rdata <= {16'h0, status_reg};
            else if (int'(rd_idx) == IDX_STARTNO)
                s_axi_rdata <= {16'h0, startno_reg};
            else if (int'(rd_idx) == IDX_CTRL)
                s_axi_rdata <= ctrl_old;
            else if (int'(rd_idx) == IDX_FLAGS)
                s_axi_rdata <= {28'h0, ready_sync_reg, state_reg != S_IDLE, error_flag, complete_flag};
            else if (int'(rd_idx) == IDX_IRQ_STAT)
                s_axi_rdata <= {30'h0, irq_stat_reg};
            else if (int'(rd_idx) == IDX_IRQ_MASK)
                s_axi_rdata <= {30'h0, irq_mask_reg};
            else
            begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Command sequencer. A new start while one is running is dropped; keeping
    // starts, restores and teaches apart on one axis is left to software.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= S_IDLE;
            axis_reg <= 2'h0;
            number_reg <= 16'h0;
            code_reg <= STATUS_OK;
            status_reg <= STATUS_OK;
            delay_cnt_reg <= '0;
            motion_cmd <= '0;
            start_complete_out <= 4'h0;
            complete_flag <= 1'b0;
            error_flag <= 1'b0;
            axis_busy_output <= 4'h0;
        end
        else
        begin
            motion_cmd.start <= 4'h0;
            motion_cmd.stop <= 4'h0;
            start_complete_out <= 4'h0;
            axis_busy_output <= axis_busy_in;
            case (state_reg)
                S_IDLE:
                    if (start_req_reg && ready_sync_reg)
                    begin
                        axis_reg <= ctrl_axis_reg;
                        number_reg <= startno_reg;
                        motion_cmd.kind <= decode_start(startno_reg);
                        motion_cmd.number <= startno_reg;
                        delay_cnt_reg <= '0;
                        if (int'(ctrl_axis_reg) >= NUM_AXES)
                        begin
                            code_reg <= ERR_AXIS;
                            state_reg <= S_FINISH;
                        end
                        else if (decode_start(startno_reg) == K_BAD)
                        begin
                            code_reg <= ERR_RANGE;
                            state_reg <= S_FINISH;
                        end
                        else
                        begin
                            code_reg <= STATUS_OK;
                            state_reg <= S_LAUNCH;
                        end
                    end
                // Waits for the axis to go idle, but never past the delay bound.
                S_LAUNCH:
                    if (!axis_busy_in[axis_reg] || delay_cnt_reg == DELAY_LAST)
                    begin
                        motion_cmd.start[axis_reg] <= 1'b1;
                        start_complete_out[axis_reg] <= 1'b1;
                        state_reg <= S_RUN;
                    end
                    else
                        delay_cnt_reg <= delay_cnt_reg + 1'b1;
                S_RUN:
                    if (stop_req_reg)
                    begin
                        motion_cmd.stop[axis_reg] <= 1'b1;
                        state_reg <= S_FINISH;
                    end
                    else if (axis_done_in[axis_reg])
                        state_reg <= S_FINISH;
                S_FINISH:
                    if (scan_end)
                    begin
                        status_reg <= code_reg;
                        complete_flag <= 1'b1;
                        error_flag <= code_reg != STATUS_OK;
                        state_reg <= S_HOLD;
                    end
                S_HOLD:
                    if (scan_end)
                    begin
                        complete_flag <= 1'b0;
                        error_flag <= 1'b0;
                        state_reg <= S_IDLE;
                    end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence flag_rise_s;
        !complete_flag ##1 complete_flag;
    endsequence
    sequence accept_s;
        state_reg == S_IDLE && start_req_reg && ready_sync_reg;
    endsequence

    flag_one_scan_a: assert property (complete_flag && scan_end |=> !complete_flag)
        else $error("completion flag outlived its scan");
    flag_at_end_a: assert property (flag_rise_s |-> $past(scan_end))
        else $error("completion flag rose outside scan end");
    err_pairs_a: assert property (flag_rise_s |-> error_flag == (status_reg != STATUS_OK))
        else $error("error flag disagrees with status word");
    not_ready_a: assert property (state_reg == S_IDLE && start_req_reg && !ready_sync_reg
        |=> state_reg == S_IDLE)
        else $error("request taken while module not ready");
    bad_number_a: assert property (accept_s ##0 (int'(ctrl_axis_reg) < NUM_AXES)
        ##0 (decode_start(startno_reg) == K_BAD) |=> code_reg == ERR_RANGE && state_reg == S_FINISH)
        else $error("range error not reported");
    bad_axis_a: assert property (accept_s ##0 (int'(ctrl_axis_reg) >= NUM_AXES) |=> code_reg == ERR_AXIS)
        else $error("axis error not reported");
    launch_bound_a: assert property (state_reg == S_LAUNCH |-> delay_cnt_reg <= DELAY_LAST)
        else $error("launch delay exceeded its bound");
    stop_ends_a: assert property (state_reg == S_RUN && stop_req_reg
        |=> state_reg == S_FINISH && code_reg == STATUS_OK)
        else $error("stop did not end the command");
    hold_stable_a: assert property (state_reg != S_IDLE ##1 state_reg != S_IDLE
        |-> $stable(axis_reg) && $stable(number_reg))
        else $error("captured request changed while busy");
    one_axis_a: assert property (motion_cmd.start != 4'h0 |-> motion_cmd.start == (4'h1 << axis_reg))
        else $error("start sent to wrong axis");
    own_done_a: assert property (state_reg == S_RUN && !stop_req_reg && !axis_done_in[axis_reg]
        |=> state_reg == S_RUN)
        else $error("completion taken from another axis");
endmodule

// >>> test/motion_model.sv
// Behavioural motion core that answers start and stop pulses for each axis.
`timescale 1ns/100ps
module motion_model
    import pstart_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire motion_cmd_t cmd,
    input wire logic [3:0] hold_busy,
    input wire logic [7:0] run_len,
    output logic [3:0] busy,
    output logic [3:0] done
);
    logic [3:0] run_reg;
    logic [7:0] left_reg [4];
    assign busy = run_reg | hold_busy;
    always_ff @(posedge aclk)
    begin
        for (int a = 0; a < 4; a++)
        begin
            done[a] <= 1'b0;
            if (!aresetn || cmd.stop[a])
            begin
                run_reg[a] <= 1'b0;
                left_reg[a] <= 8'h0;
            end
            else if (cmd.start[a] || (cmd.start[(a + 3) % 4] && cmd.kind == K_MULTI))
            begin
                // The partner axis of a multi-axis start finishes first, so a multi-axis start that
                // completes on the wrong axis shows up early.
                run_reg[a] <= 1'b1;
                left_reg[a] <= cmd.start[a] ? run_len : 8'h2;
            end
            else if (left_reg[a] != 8'h0)
            begin
                left_reg[a] <= left_reg[a] - 8'h1;
                run_reg[a] <= left_reg[a] != 8'h1;
                done[a] <= left_reg[a] == 8'h1;
            end
        end
    end
endmodule

// >>> test/tb.sv
// Self-checking bench for the positioning start command handler.
`timescale 1ns/100ps
module tb
    import pstart_pkg::*;
;
    localparam int SCAN = 20;
    localparam int SD = 16;
    typedef struct packed {
        logic [15:0] num;
        logic [1:0] axis;
        logic [15:0] code;
        logic [2:0] kind;
    } row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata, rq;
    logic [1:0] bresp, rresp, rr;
    logic scan_end = 1'b0, module_ready_in = 1'b0;
    logic [3:0] axis_busy_in, axis_done_in, start_complete_out, axis_busy_output, hold_busy = 4'h0;
    logic controller_ready_out, complete_flag, error_flag, irq;
    motion_cmd_t motion_cmd;
    int scan_cnt = 0, fails = 0, checks_done = 0;
    row_t rows [16] = '{'{POS_MIN, 2'h0, STATUS_OK, K_POS}, '{POS_MAX, 2'h1, STATUS_OK, K_POS},
        '{BLK_MIN, 2'h2, STATUS_OK, K_BLOCK}, '{BLK_MAX, 2'h0, STATUS_OK, K_BLOCK},
        '{SPC_MACH_ORIGIN, 2'h1, STATUS_OK, K_MACH_ORIGIN}, '{SPC_FAST_ORIGIN, 2'h2, STATUS_OK, K_FAST_ORIGIN},
        '{SPC_PV_CHANGE, 2'h0, STATUS_OK, K_PV_CHANGE}, '{SPC_MULTI, 2'h1, STATUS_OK, K_MULTI},
        '{16'h0000, 2'h0, ERR_RANGE, K_BAD}, '{POS_MAX + 16'h1, 2'h1, ERR_RANGE, K_BAD},
        '{BLK_MIN - 16'h1, 2'h2, ERR_RANGE, K_BAD}, '{BLK_MAX + 16'h1, 2'h0, ERR_RANGE, K_BAD},
        '{SPC_MACH_ORIGIN - 16'h1, 2'h1, ERR_RANGE, K_BAD}, '{SPC_MULTI + 16'h1, 2'h2, ERR_RANGE, K_BAD},
        '{POS_MAX, 2'h3, ERR_AXIS, K_BAD}, '{16'h0000, 2'h3, ERR_AXIS, K_BAD}};

    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        scan_cnt <= (scan_cnt == SCAN - 1) ? 0 : scan_cnt + 1;
        scan_end <= scan_cnt == SCAN - 1;
    end

    positioning_start_command #(.NUM_AXES(3), .START_DELAY(SD)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .scan_end(scan_end), .module_ready_in(module_ready_in),
        .axis_busy_in(axis_busy_in), .axis_done_in(axis_done_in), .motion_cmd(motion_cmd),
        .controller_ready_out(controller_ready_out), .start_complete_out(start_complete_out),
        .axis_busy_output(axis_busy_output), .complete_flag(complete_flag), .error_flag(error_flag), .irq(irq));
    motion_model partner (.aclk(aclk), .aresetn(aresetn), .cmd(motion_cmd), .hold_busy(hold_busy),
        .run_len(8'h28), .busy(axis_busy_in), .done(axis_done_in));

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        araddr <= a;
        wdata <= d;
        awvalid <= wr;
        wvalid <= wr;
        bready <= wr;
        arvalid <= !wr;
        rready <= !wr;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(wr ? (bvalid && bready) : (rvalid && rready)) && n < 100);
        rq = rdata;
        rr = wr ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        if (n >= 100)
            fails++;
    endtask

    task automatic run(input row_t t, input int stop_at);
        int n;
        int ln;
        logic own;
        logic launched;
        axi(1'b1, 8'h08, {16'h0, t.num});
        axi(1'b1, 8'h0c, {27'h0, 1'b1, 1'b0, t.axis, 1'b1});
        n = 0;
        ln = 0;
        own = 1'b0;
        launched = 1'b0;
        while (complete_flag !== 1'b1 && n < 400)
        begin
            @(posedge aclk);
            #1;
            n++;
            if (motion_cmd.start !== 4'h0)
            begin
                launched = 1'b1;
                ln = n;
                check("start", motion_cmd.start, 4'h1 << t.axis);
                check("start_complete", start_complete_out, 4'h1 << t.axis);
                check("kind", motion_cmd.kind, t.kind);
                check("delay", ln <= SD + 4, 1'b1);
            end
            if (launched && n == ln + 2)
                check("busy_out", axis_busy_output[t.axis], 1'b1);
            if (axis_done_in[t.axis] === 1'b1)
                own = 1'b1;
            if (motion_cmd.stop !== 4'h0)
                check("stop", motion_cmd.stop, 4'h1 << t.axis);
            if (stop_at > 0 && launched && n == ln + stop_at)
            begin
                // Rewriting the number mid-run must not disturb the captured one.
                axi(1'b1, 8'h08, 32'h5);
                axi(1'b1, 8'h0c, {27'h0, 1'b1, 1'b1, t.axis, 1'b0});
                // The stop pulse stands only in the cycle after the write lands.
                #1;
                check("stop_pulse", motion_cmd.stop, 4'h1 << t.axis);
            end
        end
        check("complete", complete_flag, 1'b1);
        check("error", error_flag, t.code != 16'h0);
        check("launched", launched, t.code == 16'h0);
        if (t.code == 16'h0 && stop_at == 0)
            check("own_done", own, 1'b1);
        if (t.code == 16'h0)
            check("number", motion_cmd.number, t.num);
        n = 0;
        while (complete_flag === 1'b1 && n < 100)
        begin
            @(posedge aclk);
            #1;
            n++;
        end
        check("flag_len", n, SCAN);
        axi(1'b0, 8'h04, 32'h0);
        check("status", rq, t.code);
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        fails++;
        test_done();
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        check("awready_rst", awready, 1'b1);
        check("flags_rst", {bvalid, rvalid, complete_flag, error_flag, irq}, 5'h0);
        axi(1'b0, 8'h00, 32'h0);
        check("reserved", rq, 32'h0);
        axi(1'b0, 8'h08, 32'h0);
        check("startno_rst", rq, STARTNO_RESET);
        axi(1'b0, 8'h1c, 32'h0);
        check("unmapped_rd", rq, 32'h0);
        check("unmapped_rresp", rr, RESP_SLVERR);
        axi(1'b1, 8'h1c, 32'h1);
        check("unmapped_wr", rr, RESP_SLVERR);
        axi(1'b1, 8'h18, 32'h3);
        // A start while the module is not ready is dropped without a trace.
        axi(1'b1, 8'h08, 32'h1);
        axi(1'b1, 8'h0c, 32'h11);
        check("cready", controller_ready_out, 1'b1);
        axi(1'b0, 8'h10, 32'h0);
        check("not_ready_busy", rq[2], 1'b0);
        repeat (3 * SCAN) @(posedge aclk);
        axi(1'b0, 8'h14, 32'h0);
        check("not_ready_irq", rq, 32'h0);
        module_ready_in <= 1'b1;
        repeat (4) @(posedge aclk);
        for (int i = 0; i < 16; i++)
        begin
            run(rows[i], 0);
            if (i == 0 || i == 8)
            begin
                axi(1'b0, 8'h14, 32'h0);
                check("irq_out", irq, 1'b1);
                check("irq_stat", rq, i == 0 ? 32'h1 : 32'h3);
                axi(1'b1, 8'h14, rq);
                repeat (2) @(posedge aclk);
                #1;
                check("irq_clear", irq, 1'b0);
            end
            if (i == 8)
                axi(1'b1, 8'h18, 32'h0);
        end
        check("irq_masked", irq, 1'b0);
        run(rows[1], 5);
        hold_busy <= 4'h1;
        run(rows[0], 0);
        hold_busy <= 4'h0;
        test_done();
    end
endmodule
